// *** design/ses_regs.svh ***
`ifndef SES_REGS_SVH
`define SES_REGS_SVH

`define SES_ADDR_CTRL 8'h00
`define SES_ADDR_SCALE 8'h04
`define SES_ADDR_ILIM 8'h08
`define SES_ADDR_GRED 8'h0C
`define SES_ADDR_STATUS 8'h10
`define SES_ADDR_IRQ_ST 8'h14
`define SES_ADDR_IRQ_MASK 8'h18

`define SES_RST_METHOD 3'h0
`define SES_RST_SCALE 16'h2710
`define SES_RST_ILIM 16'h0000
`define SES_RST_GRED 16'h1388
// ratios are in 0.01 % steps; full scale 100.00 %, scale ceiling 200.00 %
`define SES_PCT_FULL 16'h2710
`define SES_SCALE_MAX 16'h4E20
// speeds are in 0.001 rev/s steps; ceiling 10 rev/s
`define SES_SPEED_MAX 16'h2710

`define SES_IRQ_HOLD 0
`define SES_IRQ_RESUME 1
`define SES_IRQ_CANCEL 2
`define SES_IRQ_WARN 3
`define SES_IRQ_SEARCH 4
`define SES_IRQ_W 5
`endif

// *** design/ses_pkg.sv ***
package ses_pkg;
   typedef enum logic [2:0] {
      SES_IDLE,
      SES_RUN,
      SES_WAIT_WR,
      SES_HELD
   } ses_mode_e;
endpackage

// *** design/ses_ext_inputs.sv ***
`timescale 1ns/1ps
`include "ses_regs.svh"
module ses_ext_inputs
   import ses_pkg::*;
#(
   parameter int SPD_W = 16
) (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output logic irq_o,
   input wire logic pause_request_i,
   input wire logic speed_scale_request_i,
   input wire logic integral_suppress_i,
   input wire logic origin_search_start_i,
   input wire logic origin_proximity_sensor_i,
   input wire logic halt_input_i,
   input wire logic alarm_i,
   input wire logic launch_i,
   input wire logic pulse_train_i,
   input wire logic prog_write_busy_i,
   input wire logic op_done_i,
   input wire logic search_done_i,
   input wire logic abs_move_i,
   input wire logic auto_tune_command_i,
   input wire logic [SPD_W-1:0] programmed_speed_i,
   output logic busy_o,
   output logic hold_o,
   output logic resume_o,
   output logic search_start_o,
   output logic [2:0] origin_search_method_o,
   output logic proximity_o,
   output logic origin_warning_o,
   output logic [SPD_W-1:0] target_speed_o,
   output logic [15:0] integral_limit_o,
   output logic [15:0] vel_gain_o
);
   if (SPD_W < 15 || SPD_W > 16) begin : g_bad_width
      $error("SPD_W must be 15 or 16");
   end

   typedef struct packed {
      logic [5:0] s1;
      logic [5:0] s2;
      logic start_q;
      ses_mode_e mode;
      logic searching;
      logic undefined;
      logic warn;
      logic resume;
      logic start_p;
      logic [SPD_W-1:0] target;
      logic [15:0] ilim_out;
      logic [15:0] gain_out;
      logic [2:0] method;
      logic [15:0] scale;
      logic [15:0] ilim;
      logic [15:0] gred;
      logic [`SES_IRQ_W-1:0] irq_st;
      logic [`SES_IRQ_W-1:0] irq_mask;
      logic [31:0] rdata;
   } ses_state_s;

   ses_state_s st;
   ses_state_s next_st;

   logic pause_s;
   logic scale_s;
   logic supp_s;
   logic start_s;
   logic prox_s;
   logic halt_s;
   logic cancel;
   logic method_prox;
   logic [31:0] prod;
   logic [31:0] scaled;
   logic [`SES_IRQ_W-1:0] ev;

   // a pin pulse shorter than one clock may never reach the state machine
   assign pause_s = st.s2[0];
   assign scale_s = st.s2[1];
   assign supp_s = st.s2[2];
   assign start_s = st.s2[3];
   assign prox_s = st.s2[4];
   assign halt_s = st.s2[5];
   assign cancel = alarm_i | halt_s;
   assign method_prox = (st.method == 3'h1) || (st.method == 3'h3) ||
      (st.method == 3'h4) || (st.method == 3'h5);
   // scaling only during internally commanded motion
   assign prod = (scale_s && !pulse_train_i) ?
      32'(programmed_speed_i) * 32'(st.scale) :
      32'(programmed_speed_i) * 32'(`SES_PCT_FULL);
   assign scaled = prod / 32'(`SES_PCT_FULL);

   always_comb begin
      next_st = st;
      ev = '0;
      next_st.resume = 1'b0;
      next_st.start_p = 1'b0;
      next_st.warn = 1'b0;
      next_st.s1 = {halt_input_i, origin_proximity_sensor_i, origin_search_start_i,
         integral_suppress_i, speed_scale_request_i, pause_request_i};
      next_st.s2 = st.s1;
      next_st.start_q = start_s;

      // ramp between speeds is left to the motion generator, which keeps the program's
      // acceleration, deceleration and profile; only the target steps here
      next_st.target = (scaled > 32'(`SES_SPEED_MAX)) ?
         SPD_W'(`SES_SPEED_MAX) : SPD_W'(scaled);
      next_st.ilim_out = supp_s ? st.ilim : `SES_PCT_FULL;
      next_st.gain_out = (supp_s && !auto_tune_command_i) ?
         st.gred : `SES_PCT_FULL;

      unique case (st.mode)
         SES_IDLE: begin
            if (!cancel && launch_i) begin
               if (pause_s && !pulse_train_i) begin
                  next_st.mode = SES_HELD;
                  ev[`SES_IRQ_HOLD] = 1'b1;
               end else begin
                  next_st.mode = SES_RUN;
               end
            end
         end
         SES_RUN: begin
            if (cancel) begin
               next_st.mode = SES_IDLE;
               ev[`SES_IRQ_CANCEL] = 1'b1;
            end else if (op_done_i) begin
               next_st.mode = SES_IDLE;
            end else if (pause_s && !pulse_train_i) begin
               if (prog_write_busy_i) begin
                  next_st.mode = SES_WAIT_WR;
               end else begin
                  next_st.mode = SES_HELD;
                  ev[`SES_IRQ_HOLD] = 1'b1;
               end
            end
         end
         SES_WAIT_WR: begin
            if (cancel) begin
               next_st.mode = SES_IDLE;
               ev[`SES_IRQ_CANCEL] = 1'b1;
            end else if (!prog_write_busy_i) begin
               next_st.mode = pause_s ? SES_HELD : SES_RUN;
               ev[`SES_IRQ_HOLD] = pause_s;
            end
         end
         SES_HELD: begin
            if (cancel) begin
               next_st.mode = SES_IDLE;
               ev[`SES_IRQ_CANCEL] = 1'b1;
            end else if (!pause_s) begin
               next_st.mode = SES_RUN;
               next_st.resume = 1'b1;
               ev[`SES_IRQ_RESUME] = 1'b1;
            end
         end
      endcase

      // origin search is internal motion: it starts like a launch
      if (start_s && !st.start_q && !cancel && st.mode == SES_IDLE) begin
         next_st.start_p = 1'b1;
         next_st.searching = 1'b1;
         next_st.mode = pause_s ? SES_HELD : SES_RUN;
         ev[`SES_IRQ_SEARCH] = 1'b1;
      end else if (st.searching && search_done_i) begin
         next_st.searching = 1'b0;
         next_st.undefined = 1'b0;
      end else if (st.searching && (cancel || next_st.mode == SES_IDLE)) begin
         next_st.searching = 1'b0;
         next_st.undefined = 1'b1;
      end
      if (abs_move_i && st.undefined) begin
         next_st.warn = 1'b1;
         ev[`SES_IRQ_WARN] = 1'b1;
      end

      next_st.rdata = 32'h0;
      if (rd_i) begin
         unique case (addr_i)
            `SES_ADDR_CTRL: next_st.rdata = {29'h0, st.method};
            `SES_ADDR_SCALE: next_st.rdata = {16'h0, st.scale};
            `SES_ADDR_ILIM: next_st.rdata = {16'h0, st.ilim};
            `SES_ADDR_GRED: next_st.rdata = {16'h0, st.gred};
            `SES_ADDR_STATUS: next_st.rdata = {20'h0, st.s2, st.undefined,
               st.searching, 1'b0, 3'(st.mode)};
            `SES_ADDR_IRQ_ST: next_st.rdata = {27'h0, st.irq_st};
            `SES_ADDR_IRQ_MASK: next_st.rdata = {27'h0, st.irq_mask};
            default: next_st.rdata = 32'h0;
         endcase
      end
      if (wr_i) begin
         unique case (addr_i)
            `SES_ADDR_CTRL: next_st.method = wdata_i[2:0];
            `SES_ADDR_SCALE: next_st.scale = (wdata_i[15:0] > `SES_SCALE_MAX) ?
               `SES_SCALE_MAX : wdata_i[15:0];
            `SES_ADDR_ILIM: next_st.ilim = (wdata_i[15:0] > `SES_PCT_FULL) ?
               `SES_PCT_FULL : wdata_i[15:0];
            `SES_ADDR_GRED: next_st.gred = (wdata_i[15:0] > `SES_PCT_FULL) ?
               `SES_PCT_FULL : wdata_i[15:0];
            `SES_ADDR_IRQ_ST: next_st.irq_st = st.irq_st & ~wdata_i[`SES_IRQ_W-1:0];
            `SES_ADDR_IRQ_MASK: next_st.irq_mask = wdata_i[`SES_IRQ_W-1:0];
            default: ;
         endcase
      end
      // new events win over a write-one clear in the same cycle
      next_st.irq_st = next_st.irq_st | ev;
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         st <= '0;
         st.mode <= SES_IDLE;
         st.target <= '0;
         st.ilim_out <= `SES_PCT_FULL;
         st.gain_out <= `SES_PCT_FULL;
         st.method <= `SES_RST_METHOD;
         st.scale <= `SES_RST_SCALE;
         st.ilim <= `SES_RST_ILIM;
         st.gred <= `SES_RST_GRED;
      end else begin
         st <= next_st;
      end
   end

   assign rdata_o = st.rdata;
   assign irq_o = |(st.irq_st & st.irq_mask);
   assign busy_o = (st.mode != SES_IDLE);
   assign hold_o = (st.mode == SES_HELD);
   assign resume_o = st.resume;
   assign search_start_o = st.start_p;
   assign origin_search_method_o = st.method;
   assign proximity_o = prox_s && st.searching && method_prox;
   assign origin_warning_o = st.warn;
   assign target_speed_o = st.target;
   assign integral_limit_o = st.ilim_out;
   assign vel_gain_o = st.gain_out;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);

   sequence s_run_paused;
      st.mode == SES_RUN && pause_s && !pulse_train_i && !cancel && !op_done_i;
   endsequence
   sequence s_held_release;
      st.mode == SES_HELD && !pause_s && !cancel;
   endsequence

   property p_pause_holds;
      s_run_paused ##0 !prog_write_busy_i |=> hold_o && busy_o;
   endproperty
   a_pause_holds: assert property (p_pause_holds) else $error("pause did not hold");
   property p_pulse_ignored;
      (st.mode == SES_RUN && pulse_train_i && !cancel && !op_done_i) |=> !hold_o;
   endproperty
   a_pulse_ignored: assert property (p_pulse_ignored) else $error("pulse train held");
   property p_write_first;
      s_run_paused ##0 prog_write_busy_i |=> !hold_o ##0 st.mode == SES_WAIT_WR;
   endproperty
   a_write_first: assert property (p_write_first) else $error("held mid write");
   property p_held_busy;
      (hold_o && pause_s && !cancel) |=> hold_o && busy_o;
   endproperty
   a_held_busy: assert property (p_held_busy) else $error("busy open while held");
   property p_resume;
      s_held_release |=> resume_o && !hold_o ##1 !resume_o;
   endproperty
   a_resume: assert property (p_resume) else $error("no resume");
   property p_cancel;
      (st.mode != SES_IDLE && cancel) |=> !busy_o ##1 (!busy_o || $past(launch_i)
         || $past(start_s));
   endproperty
   a_cancel: assert property (p_cancel) else $error("cancel left busy");
   property p_launch_paused;
      (st.mode == SES_IDLE && launch_i && pause_s && !pulse_train_i && !cancel)
         |=> busy_o && hold_o;
   endproperty
   a_launch_paused: assert property (p_launch_paused) else $error("launch ran");
   property p_no_scale;
      !scale_s |=> target_speed_o == (($past(programmed_speed_i) > SPD_W'(`SES_SPEED_MAX))
         ? SPD_W'(`SES_SPEED_MAX) : $past(programmed_speed_i));
   endproperty
   a_no_scale: assert property (p_no_scale) else $error("unscaled speed wrong");
   property p_clamp;
      target_speed_o <= SPD_W'(`SES_SPEED_MAX);
   endproperty
   a_clamp: assert property (p_clamp) else $error("speed over ceiling");
   property p_ilim;
      supp_s |=> integral_limit_o == $past(st.ilim);
   endproperty
   a_ilim: assert property (p_ilim) else $error("integral limit wrong");
   property p_gain;
      (supp_s && !auto_tune_command_i) |=> vel_gain_o == $past(st.gred);
   endproperty
   a_gain: assert property (p_gain) else $error("gain not reduced");
   property p_tune;
      auto_tune_command_i |=> vel_gain_o == `SES_PCT_FULL;
   endproperty
   a_tune: assert property (p_tune) else $error("gain reduced in tuning");
   property p_edge;
      search_start_o |-> $past(start_s) && !$past(st.start_q);
   endproperty
   a_edge: assert property (p_edge) else $error("search without rising edge");
   property p_warn;
      (abs_move_i && st.undefined) |=> origin_warning_o;
   endproperty
   a_warn: assert property (p_warn) else $error("warning missing");
   property p_prox;
      proximity_o |-> st.searching && method_prox;
   endproperty
   a_prox: assert property (p_prox) else $error("proximity misused");

   // the six request, sensor and halt pins pass exactly two flops, so each change is acted on once
   property p_sync;
      (!$past(srst_i) && !$past(srst_i, 2)) |-> st.s2 == {$past(halt_input_i, 2),
         $past(origin_proximity_sensor_i, 2), $past(origin_search_start_i, 2),
         $past(integral_suppress_i, 2), $past(speed_scale_request_i, 2),
         $past(pause_request_i, 2)};
   endproperty
   a_sync: assert property (p_sync) else $error("pin not synchronised");
   property p_no_restart;
      (st.mode == SES_IDLE && !launch_i && !(start_s && !st.start_q)) |=> !busy_o;
   endproperty
   a_no_restart: assert property (p_no_restart) else $error("restart without command");
   property p_wait_release;
      (st.mode == SES_WAIT_WR && !cancel && !prog_write_busy_i) |=>
         hold_o == $past(pause_s);
   endproperty
   a_wait_release: assert property (p_wait_release) else $error("write wait exit wrong");
   property p_search_idle;
      (start_s && !st.start_q && st.mode != SES_IDLE) |=> !search_start_o;
   endproperty
   a_search_idle: assert property (p_search_idle) else $error("search while busy");
   property p_abort;
      (st.searching && cancel && !search_done_i) |=> st.undefined;
   endproperty
   a_abort: assert property (p_abort) else $error("abort left origin defined");
   property p_scale_sat;
      (wr_i && addr_i == `SES_ADDR_SCALE) |=> st.scale <= `SES_SCALE_MAX;
   endproperty
   a_scale_sat: assert property (p_scale_sat) else $error("scale over range");
   property p_scale_on;
      (scale_s && !pulse_train_i) |=>
         ((32'($past(programmed_speed_i)) * 32'($past(st.scale)) / 32'(`SES_PCT_FULL)) >
         32'(`SES_SPEED_MAX)) ? 32'(target_speed_o) == 32'(`SES_SPEED_MAX) :
         32'(target_speed_o) == 32'($past(programmed_speed_i)) * 32'($past(st.scale)) /
         32'(`SES_PCT_FULL);
   endproperty
   a_scale_on: assert property (p_scale_on) else $error("scaled speed wrong");
   property p_no_reduce;
      !supp_s |=> integral_limit_o == `SES_PCT_FULL && vel_gain_o == `SES_PCT_FULL;
   endproperty
   a_no_reduce: assert property (p_no_reduce) else $error("reduction while off");

   // bus and flag behaviour that this block adds around the rules
   property p_rdata_idle;
      !rd_i |=> rdata_o == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
   property p_set_wins;
      ev != '0 |=> (st.irq_st & $past(ev)) == $past(ev);
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost to clear");
   property p_irq_clear;
      (wr_i && addr_i == `SES_ADDR_IRQ_ST && ev == '0) |=>
         (32'(st.irq_st) & $past(wdata_i)) == 32'h0;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("status bit not cleared");
   property p_done_idle;
      (st.mode == SES_RUN && op_done_i && !cancel) |=> !busy_o;
   endproperty
   a_done_idle: assert property (p_done_idle) else $error("busy after done");
endmodule

// *** tb/ses_master_model.sv ***
`timescale 1ns/1ps
// master controller side: raises the search start pin only when the device is ready
module ses_master_model (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic busy_i,
   input wire logic servo_on_i,
   input wire logic alarm_i,
   input wire logic halt_i,
   input wire logic want_i,
   output logic start_o
);
   // start stays up while wanted, so a later drop gives the device a falling edge to ignore
   always_ff @(posedge mclk_i) begin
      if (srst_i || !want_i) begin
         start_o <= 1'b0;
      end else if (!busy_i && servo_on_i && !alarm_i && !halt_i) begin
         start_o <= 1'b1;
      end
   end
endmodule

// *** tb/servo_extended_input_handler_tb.sv ***
`timescale 1ns/1ps
module servo_extended_input_handler_tb;
   import ses_pkg::*;
   logic mclk_i, srst_i, wr_i, rd_i, irq_o, want;
   logic [7:0] addr_i;
   logic [31:0] wdata_i, rdata_o;
   logic pause_request_i, speed_scale_request_i, integral_suppress_i, origin_search_start_i;
   logic origin_proximity_sensor_i, halt_input_i, alarm_i, launch_i, pulse_train_i;
   logic prog_write_busy_i, op_done_i, search_done_i, abs_move_i, auto_tune_command_i;
   logic [15:0] programmed_speed_i, target_speed_o, integral_limit_o, vel_gain_o;
   logic busy_o, hold_o, resume_o, search_start_o, proximity_o, origin_warning_o;
   logic [2:0] origin_search_method_o;
   int mismatches, tests_run, cyc, n_res, n_srch, n_warn, r0, s0, w0;
   int seed = 32'hC4B236D5;
   logic [15:0] sc, pg, il, gr;
   logic on, pt;

   ses_ext_inputs i_ses_ext_inputs (.mclk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
      .rdata_o, .irq_o, .pause_request_i, .speed_scale_request_i, .integral_suppress_i,
      .origin_search_start_i, .origin_proximity_sensor_i, .halt_input_i, .alarm_i,
      .launch_i, .pulse_train_i, .prog_write_busy_i, .op_done_i, .search_done_i,
      .abs_move_i, .auto_tune_command_i, .programmed_speed_i, .busy_o, .hold_o, .resume_o,
      .search_start_o, .origin_search_method_o, .proximity_o, .origin_warning_o,
      .target_speed_o, .integral_limit_o, .vel_gain_o);
   ses_master_model i_ses_master_model (.mclk_i, .srst_i, .busy_i(busy_o),
      .servo_on_i(1'b1), .alarm_i, .halt_i(halt_input_i), .want_i(want),
      .start_o(origin_search_start_i));

   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end

   // pulse outputs stand one cycle, so they are counted rather than sampled
   always @(posedge mclk_i) begin
      cyc++;
      if (resume_o === 1'b1) n_res++;
      if (search_start_o === 1'b1) n_srch++;
      if (origin_warning_o === 1'b1) n_warn++;
      if (cyc == 20000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic finish_test();
      if (mismatches == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         mismatches++;
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 chk(n, e, rdata_o);
   endtask
   task automatic launch();
      @(posedge mclk_i) launch_i <= 1'b1;
      @(posedge mclk_i) launch_i <= 1'b0;
   endtask
   task automatic done();
      @(posedge mclk_i) op_done_i <= 1'b1;
      @(posedge mclk_i) op_done_i <= 1'b0;
   endtask
   function automatic logic [15:0] rnd(input int lim);
      return 16'($unsigned($random(seed)) % lim);
   endfunction
   function automatic logic [15:0] exp_spd(input logic [15:0] p, input logic [15:0] s,
                                           input logic en);
      logic [31:0] v;
      v = en ? (32'(p) * 32'(s)) / 32'd10000 : 32'(p);
      return (v > 32'd10000) ? 16'h2710 : v[15:0];
   endfunction

   initial begin
      {wr_i, rd_i, want, addr_i, wdata_i, programmed_speed_i} = '0;
      {pause_request_i, speed_scale_request_i, integral_suppress_i} = '0;
      {origin_proximity_sensor_i, halt_input_i, alarm_i, launch_i, pulse_train_i} = '0;
      {prog_write_busy_i, op_done_i, search_done_i, abs_move_i, auto_tune_command_i} = '0;
      srst_i = 1'b1;
      repeat (6) @(posedge mclk_i);
      srst_i <= 1'b0;
      rd(8'h00, 32'h0, "ctrl");
      rd(8'h04, 32'h2710, "scale");
      rd(8'h08, 32'h0, "ilim");
      rd(8'h0C, 32'h1388, "gred");
      rd(8'h1C, 32'h0, "unmapped");
      launch();
      @(posedge mclk_i) pause_request_i <= 1'b1;
      tick(6);
      chk("hold", 1, hold_o);
      chk("busy", 1, busy_o);
      chk("irq", 0, irq_o);
      rd(8'h10, 32'h43, "status");
      wr(8'h18, 32'h1);
      rd(8'h18, 32'h1, "mask");
      tick(2);
      chk("irq", 1, irq_o);
      wr(8'h14, 32'h1);
      tick(2);
      chk("irq", 0, irq_o);
      rd(8'h14, 32'h0, "irq status");
      r0 = n_res;
      @(posedge mclk_i) pause_request_i <= 1'b0;
      tick(6);
      chk("hold", 0, hold_o);
      chk("resume", r0 + 1, n_res);
      done();
      tick(2);
      chk("busy", 0, busy_o);
      @(posedge mclk_i) pulse_train_i <= 1'b1;
      launch();
      @(posedge mclk_i) pause_request_i <= 1'b1;
      tick(6);
      chk("hold", 0, hold_o);
      done();
      @(posedge mclk_i) pulse_train_i <= 1'b0;
      @(posedge mclk_i) pause_request_i <= 1'b0;
      tick(4);
      launch();
      @(posedge mclk_i) prog_write_busy_i <= 1'b1;
      @(posedge mclk_i) pause_request_i <= 1'b1;
      tick(6);
      chk("hold", 0, hold_o);
      @(posedge mclk_i) prog_write_busy_i <= 1'b0;
      tick(3);
      chk("hold", 1, hold_o);
      r0 = n_res;
      @(posedge mclk_i) alarm_i <= 1'b1;
      tick(2);
      chk("busy", 0, busy_o);
      chk("hold", 0, hold_o);
      @(posedge mclk_i) alarm_i <= 1'b0;
      @(posedge mclk_i) pause_request_i <= 1'b0;
      tick(6);
      chk("busy", 0, busy_o);
      chk("resume", r0, n_res);
      @(posedge mclk_i) pause_request_i <= 1'b1;
      tick(6);
      launch();
      tick(2);
      chk("busy", 1, busy_o);
      chk("hold", 1, hold_o);
      @(posedge mclk_i) pause_request_i <= 1'b0;
      tick(6);
      done();
      for (int i = 0; i < 24; i++) begin
         sc = (i == 0) ? 16'h4E20 : rnd(20001);
         pg = (i == 0) ? 16'h2328 : rnd(65536);
         on = (i < 2) ? 1'b1 : rnd(2) == 0;
         pt = (i < 2) ? 1'b0 : rnd(4) == 0;
         wr(8'h04, (i == 1) ? 32'h7530 : 32'(sc));
         if (i == 1) sc = 16'h4E20;
         @(posedge mclk_i);
         programmed_speed_i <= pg;
         speed_scale_request_i <= on;
         pulse_train_i <= pt;
         tick(5);
         chk("target", exp_spd(pg, sc, on && !pt), target_speed_o);
      end
      @(posedge mclk_i) pulse_train_i <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         il = rnd(10001);
         gr = rnd(10001);
         wr(8'h08, 32'(il));
         wr(8'h0C, 32'(gr));
         @(posedge mclk_i);
         on = (i < 2) ? 1'b1 : rnd(2) == 0;
         integral_suppress_i <= on;
         auto_tune_command_i <= (i == 1);
         tick(5);
         chk("ilim", on ? il : 16'h2710, integral_limit_o);
         chk("gain", (on && i != 1) ? gr : 16'h2710, vel_gain_o);
      end
      for (int m = 0; m < 6; m++) begin
         wr(8'h00, 32'(m));
         @(posedge mclk_i) origin_proximity_sensor_i <= 1'b1;
         s0 = n_srch;
         w0 = n_warn;
         @(posedge mclk_i) want <= 1'b1;
         tick(6);
         chk("search", s0 + 1, n_srch);
         chk("busy", 1, busy_o);
         chk("prox", m inside {1, 3, 4, 5}, proximity_o);
         chk("method", m, origin_search_method_o);
         @(posedge mclk_i) want <= 1'b0;
         tick(6);
         chk("search", s0 + 1, n_srch);
         // the last method is aborted by halt instead of completing
         if (m == 5) begin
            @(posedge mclk_i) halt_input_i <= 1'b1;
            tick(5);
            chk("busy", 0, busy_o);
            @(posedge mclk_i) halt_input_i <= 1'b0;
         end else begin
            @(posedge mclk_i) search_done_i <= 1'b1;
            @(posedge mclk_i) search_done_i <= 1'b0;
            done();
         end
         origin_proximity_sensor_i <= 1'b0;
         tick(5);
         @(posedge mclk_i) abs_move_i <= 1'b1;
         @(posedge mclk_i) abs_move_i <= 1'b0;
         tick(3);
         chk("warn", w0 + (m == 5), n_warn);
      end
      finish_test();
   end
endmodule
